//--- mhp_defines.svh
// Constants for the multiplexed address/data host port
`ifndef MHP_DEFINES_SVH
`define MHP_DEFINES_SVH

// Width of the shared address/data bus
`define MHP_BUS_W        8
// Width of the synchroniser vectors and bit positions of the strobes inside them
`define MHP_STB_W        4
`define MHP_STB_ALE      0
`define MHP_STB_CS       1
`define MHP_STB_RD       2
`define MHP_STB_WR       3
// Idle pin levels: address strobe low, active-low strobes high
`define MHP_STB_IDLE     4'hE
// Reset values of the captured words and the output data
`define MHP_ADDR_RST     8'h00
`define MHP_DATA_RST     8'h00
// Cycles from a memory read pulse to valid read data
`define MHP_MEM_RD_LAT   1

`endif

//--- mhp_pkg.sv
// Types shared by the host port modules
package mhp_pkg;

  // Phases of one host bus cycle, one-hot
  typedef enum logic [3:0] {
    MHP_IDLE  = 4'b0001,
    MHP_ADDR  = 4'b0010,
    MHP_READ  = 4'b0100,
    MHP_WRITE = 4'b1000
  } mhp_state_t;

  // Which store an access reaches
  typedef enum logic {
    MHP_TGT_CLOCK = 1'b0,
    MHP_TGT_XRAM  = 1'b1
  } mhp_target_t;

endpackage

//--- mhp_strobe_if.sv
// Synchronised strobes and bus samples passed from the pin sampler to the port logic
interface mhp_strobe_if;
  logic [7:0] bus_s3;
  logic       ale_s3;
  logic       wr_n_s3;
  logic       cs_n_lvl;
  logic       rd_n_lvl;
  logic       wr_n_lvl;
  logic       ale_fall;
  logic       rd_fall;
  logic       rd_rise;
  logic       wr_fall;
  logic       wr_rise;

  modport src (
    output bus_s3, ale_s3, wr_n_s3, cs_n_lvl, rd_n_lvl, wr_n_lvl,
    output ale_fall, rd_fall, rd_rise, wr_fall, wr_rise
  );
  modport dst (
    input bus_s3, ale_s3, wr_n_s3, cs_n_lvl, rd_n_lvl, wr_n_lvl,
    input ale_fall, rd_fall, rd_rise, wr_fall, wr_rise
  );
endinterface

//--- mhp_pin_sync.sv
// Three-stage pin sampler with agreement filter and edge pulses
`include "mhp_defines.svh"
module mhp_pin_sync
  import mhp_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire logic [`MHP_BUS_W-1:0]  bus_pin,
  input  wire logic [`MHP_STB_W-1:0]  stb_pin,
  mhp_strobe_if.src                   sif
);

  logic [`MHP_STB_W-1:0] s1_reg;
  logic [`MHP_STB_W-1:0] s2_reg;
  logic [`MHP_STB_W-1:0] s3_reg;
  logic [`MHP_STB_W-1:0] lvl_reg;
  logic [`MHP_STB_W-1:0] lvl_next;
  logic [`MHP_STB_W-1:0] rise_reg;
  logic [`MHP_STB_W-1:0] fall_reg;
  logic [`MHP_BUS_W-1:0] b1_reg;
  logic [`MHP_BUS_W-1:0] b2_reg;
  logic [`MHP_BUS_W-1:0] b3_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Strobe and bus pipelines; bus kept in step so stage 3 pairs with strobes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg <= `MHP_STB_IDLE;
      s2_reg <= `MHP_STB_IDLE;
      s3_reg <= `MHP_STB_IDLE;
      b1_reg <= `MHP_DATA_RST;
      b2_reg <= `MHP_DATA_RST;
      b3_reg <= `MHP_DATA_RST;
    end else begin
      s1_reg <= stb_pin;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      b1_reg <= bus_pin;
      b2_reg <= b1_reg;
      b3_reg <= b2_reg;
    end
  end

  // A level change counts only once stages two and three agree
  always_comb begin
    lvl_next = (s2_reg & ~(s2_reg ^ s3_reg)) | (lvl_reg & (s2_reg ^ s3_reg));
  end

  // Filtered level and one-cycle edge pulses
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lvl_reg  <= `MHP_STB_IDLE;
      rise_reg <= '0;
      fall_reg <= '0;
    end else begin
      lvl_reg  <= lvl_next;
      rise_reg <= lvl_next & ~lvl_reg;
      fall_reg <= ~lvl_next & lvl_reg;
    end
  end

  assign sif.bus_s3   = b3_reg;
  assign sif.ale_s3   = s3_reg[`MHP_STB_ALE];
  assign sif.wr_n_s3  = s3_reg[`MHP_STB_WR];
  assign sif.cs_n_lvl = lvl_reg[`MHP_STB_CS];
  assign sif.rd_n_lvl = lvl_reg[`MHP_STB_RD];
  assign sif.wr_n_lvl = lvl_reg[`MHP_STB_WR];
  assign sif.ale_fall = fall_reg[`MHP_STB_ALE];
  assign sif.rd_fall  = fall_reg[`MHP_STB_RD];
  assign sif.rd_rise  = rise_reg[`MHP_STB_RD];
  assign sif.wr_fall  = fall_reg[`MHP_STB_WR];
  assign sif.wr_rise  = rise_reg[`MHP_STB_WR];

endmodule

//--- mhp_host_port.sv
// Multiplexed address/data host port of the clock device
// Functional notes
// - Same eight pins carry the address first, then data, in every bus cycle.
// - Host sets address before late address strobe; device captures it then.
// - Device drives eight read data bits in the late part of read strobe.
// - Read strobe rising ends the read and releases the bus.
// - Same bus reaches the extended user RAM as well as clock registers.
// - Internal fetch overlaps the address-to-data turnaround, adding no delay.
// - Address is latched on the falling edge of the address strobe.
// - Chip select low throughout a strobe is needed for any data transfer.
// - Bus drivers only on during read strobe; write strobe sets write window.
`include "mhp_defines.svh"
module mhp_host_port
  import mhp_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   reset_n,
  // Host pins
  input  wire logic [`MHP_BUS_W-1:0]  muxed_bus_in,
  output logic      [`MHP_BUS_W-1:0]  muxed_bus_out,
  output logic                        muxed_bus_oe,
  input  wire logic                   ale,
  input  wire logic                   cs_n,
  input  wire logic                   rd_n,
  input  wire logic                   wr_n,
  // Bank steering from the device's own control logic
  input  wire logic                   xram_select,
  // Internal store side
  output logic      [`MHP_BUS_W-1:0]  mem_addr,
  output logic                        mem_xram,
  output logic                        mem_rd,
  output logic                        mem_wr,
  output logic      [`MHP_BUS_W-1:0]  mem_wdata,
  input  wire logic [`MHP_BUS_W-1:0]  mem_rdata,
  output logic                        cycle_busy
);

  logic                  rst_meta_reg;
  logic                  rst_n_reg;
  mhp_state_t            state_reg;
  mhp_state_t            state_next;
  logic [`MHP_BUS_W-1:0] addr_cand_reg;
  logic [`MHP_BUS_W-1:0] addr_reg;
  logic                  tgt_reg;
  logic [`MHP_BUS_W-1:0] wdata_cand_reg;
  logic [`MHP_BUS_W-1:0] wdata_reg;
  logic                  cs_ok_reg;
  logic                  drive_reg;
  logic [`MHP_BUS_W-1:0] rdata_reg;
  logic                  rd_pend_reg;
  logic                  rd_req;
  logic                  wr_commit;

  mhp_strobe_if sif ();

  ////////////////////////////////////////////////////////////////////////////
  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg    <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg    <= rst_meta_reg;
    end
  end

  // Pin sampler; strobes carry no clock of their own
  mhp_pin_sync u_sync (
    .clk     (clk),
    .rst_n   (rst_n_reg),
    .bus_pin (muxed_bus_in),
    .stb_pin ({wr_n, rd_n, cs_n, ale}),
    .sif     (sif)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Address candidate follows the bus while the strobe is sampled high,
  // so the last sample before the fall is the one kept
  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      addr_cand_reg <= `MHP_ADDR_RST;
    end else if (sif.ale_s3) begin
      addr_cand_reg <= sif.bus_s3;
    end
  end

  // Address and bank latched at the strobe fall, chip select not needed
  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      addr_reg <= `MHP_ADDR_RST;
      tgt_reg  <= MHP_TGT_CLOCK;
    end else if (sif.ale_fall) begin
      addr_reg <= addr_cand_reg;
      tgt_reg  <= xram_select;
    end
  end

  // Write data candidate tracks the bus while the write strobe is low;
  // the value sampled last before the rise is the one committed
  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      wdata_cand_reg <= `MHP_DATA_RST;
    end else if (!sif.wr_n_s3) begin
      wdata_cand_reg <= sif.bus_s3;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus cycle phases
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      MHP_IDLE: begin
        if (sif.ale_fall) begin
          state_next = MHP_ADDR;
        end
      end
      MHP_ADDR: begin
        if (sif.rd_fall) begin
          state_next = MHP_READ;
        end else if (sif.wr_fall) begin
          state_next = MHP_WRITE;
        end
      end
      MHP_READ: begin
        if (sif.rd_rise) begin
          state_next = MHP_IDLE;
        end
      end
      MHP_WRITE: begin
        if (sif.wr_rise) begin
          state_next = MHP_IDLE;
        end
      end
      default: begin
        state_next = MHP_IDLE;
      end
    endcase
    // A new address strobe always restarts the cycle
    if (sif.ale_fall) begin
      state_next = MHP_ADDR;
    end
  end

  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      state_reg <= MHP_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Chip select must stay low for the whole strobe
  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      cs_ok_reg <= 1'b0;
    end else if (sif.rd_fall || sif.wr_fall) begin
      cs_ok_reg <= !sif.cs_n_lvl;
    end else if (sif.cs_n_lvl) begin
      cs_ok_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write commit at the write strobe rise, only for a selected cycle
  assign wr_commit = (state_reg == MHP_WRITE) && sif.wr_rise && cs_ok_reg && !sif.cs_n_lvl;

  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      wdata_reg <= `MHP_DATA_RST;
      mem_wr    <= 1'b0;
    end else begin
      mem_wr <= wr_commit;
      if (wr_commit) begin
        wdata_reg <= wdata_cand_reg;
      end
    end
  end

  // Fetch starts as soon as the address is known, hiding the bus
  // turnaround; a refetch after a write keeps read-after-write coherent
  assign rd_req = sif.ale_fall || wr_commit || (sif.rd_fall && !sif.cs_n_lvl);

  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      mem_rd      <= 1'b0;
      rd_pend_reg <= 1'b0;
      rdata_reg   <= `MHP_DATA_RST;
    end else begin
      mem_rd      <= rd_req;
      rd_pend_reg <= mem_rd;
      if (rd_pend_reg) begin
        rdata_reg <= mem_rdata;
      end
    end
  end

  // Drive permission follows the synchronised read strobe
  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      drive_reg <= 1'b0;
    end else if (sif.rd_rise || sif.cs_n_lvl) begin
      drive_reg <= 1'b0;
    end else if (sif.rd_fall && state_reg == MHP_ADDR) begin
      drive_reg <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Enable is also gated by the raw pins so the bus is let go the moment
  // the read strobe or chip select rises, not five clocks later
  assign muxed_bus_oe  = drive_reg && !rd_n && !cs_n;
  assign muxed_bus_out = rdata_reg;
  assign mem_addr      = addr_reg;
  assign mem_xram      = tgt_reg;
  assign mem_wdata     = wdata_reg;
  assign cycle_busy    = (state_reg != MHP_IDLE);

endmodule

//--- mhp_host_port_checker.sv
// Timing assertions on the host port pins and store strobes
`include "mhp_defines.svh"
module mhp_host_port_checker (
  input wire logic                 clk,
  input wire logic                 reset_n,
  input wire logic                 ale,
  input wire logic                 cs_n,
  input wire logic                 rd_n,
  input wire logic                 wr_n,
  input wire logic                 muxed_bus_oe,
  input wire logic                 mem_rd,
  input wire logic                 mem_wr,
  input wire logic [`MHP_BUS_W-1:0] mem_addr,
  input wire logic                 cycle_busy
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////
  // Selected read strobe after a settled address phase
  sequence s_rd_start;
    $fell(ale) ##[4:30] ($fell(rd_n) && !cs_n);
  endsequence
  // Pin drivers follow the raw strobes, so release needs no clock
  a_oe_gate: assert property (muxed_bus_oe |-> !rd_n && !cs_n)
    else $error("bus driven outside a selected read strobe");
  a_rd_release: assert property ($rose(rd_n) |-> !muxed_bus_oe)
    else $error("bus still driven after read strobe end");
  a_oe_cause: assert property ($rose(muxed_bus_oe) |-> !$past(rd_n, 4) && !$past(cs_n, 4))
    else $error("drive began before the read strobe was seen");
  a_oe_in_time: assert property (s_rd_start |-> ##[1:7] (muxed_bus_oe || rd_n || cs_n))
    else $error("read data not driven in time");
  a_oe_busy: assert property (muxed_bus_oe |-> cycle_busy)
    else $error("bus driven outside a bus cycle");
  a_addr_at_fall: assert property ($changed(mem_addr) |-> !ale && !$past(ale))
    else $error("address changed while strobe high");
  a_prefetch_overlap: assert property ($fell(ale) |-> ##[3:7] mem_rd)
    else $error("no fetch after address latch");
  a_wr_single: assert property (mem_wr |-> $past(wr_n, 4) ##1 !mem_wr)
    else $error("write not one pulse after strobe rise");
  a_wr_no_cs: assert property (($rose(wr_n) && cs_n) |-> !mem_wr [*8])
    else $error("write committed without chip select");
endmodule
////////////////////////////////////////
// Attach to every instance of the port
bind mhp_host_port mhp_host_port_checker mhp_host_port_checker_inst (
  .clk(clk), .reset_n(reset_n), .ale(ale), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
  .muxed_bus_oe(muxed_bus_oe), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_addr(mem_addr),
  .cycle_busy(cycle_busy)
);

//--- mhp_host_model.sv
// Host processor model driving the shared address/data pins
module mhp_host_model (
  input  wire logic       clk,
  output logic            ale,
  output logic            cs_n,
  output logic            rd_n,
  output logic            wr_n,
  output logic [7:0]      h_d,
  output logic            h_oe,
  input  wire logic [7:0] pin
);
  timeunit 1ns;
  timeprecision 1ps;
  ////////////////////////////////////////
  // Idle pins at time zero
  initial begin
    {ale, h_oe, h_d} = '0;
    {cs_n, rd_n, wr_n} = 3'b111;
  end
  // Changes land just after an edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // One bus cycle; e=0 skips the address phase, len sets strobe width
  task automatic cyc(input logic [7:0] a, input logic w, input logic [7:0] d,
                     input logic c, input logic e, input int len, output logic [7:0] q);
    if (e) begin
      h_d  = a;
      h_oe = 1'b1;
      ale  = 1'b1;
      tick(4);
      ale = 1'b0;
      tick(2);
    end
    // Released bus shows a changed value, never the stale one
    h_oe = 1'b0;
    h_d  = ~h_d;
    tick(3);
    cs_n = ~c;
    if (w) begin
      h_d  = d;
      h_oe = 1'b1;
      wr_n = 1'b0;
      tick(len);
      wr_n = 1'b1;
      tick(1);
      h_oe = 1'b0;
      h_d  = ~h_d;
    end else begin
      rd_n = 1'b0;
      tick(len);
      q    = pin;
      rd_n = 1'b1;
    end
    cs_n = 1'b1;
    tick(12);
  endtask
endmodule

//--- mhp_host_port_tb_top.sv
// Self-checking bench for the multiplexed host port
`include "mhp_defines.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin miscompares++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module mhp_host_port_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk = 1'b0;
  logic       reset_n = 1'b0;
  logic       xram_select = 1'b0;
  logic       ale, cs_n, rd_n, wr_n, h_oe, muxed_bus_oe, mem_xram, mem_rd, mem_wr, cycle_busy;
  logic [7:0] h_d, muxed_bus_in, muxed_bus_out, mem_addr, mem_wdata;
  logic [7:0] mem_rdata = 8'h00;
  logic [7:0] store [0:511];
  logic [7:0] last_a, last_d;
  logic       last_x;
  int         wcnt = 0;
  int         ocnt = 0;
  int         clash = 0;
  int         miscompares = 0;
  int         comparisons = 0;
  ////////////////////////////////////////
  always #5 clk = ~clk;
  // Pin level: device wins while it drives
  assign muxed_bus_in = muxed_bus_oe ? muxed_bus_out : h_d;
  mhp_host_port mhp_host_port_inst (
    .clk(clk), .reset_n(reset_n), .muxed_bus_in(muxed_bus_in), .muxed_bus_out(muxed_bus_out),
    .muxed_bus_oe(muxed_bus_oe), .ale(ale), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
    .xram_select(xram_select), .mem_addr(mem_addr), .mem_xram(mem_xram), .mem_rd(mem_rd),
    .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .cycle_busy(cycle_busy)
  );
  mhp_host_model mhp_host_model_inst (
    .clk(clk), .ale(ale), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .h_d(h_d), .h_oe(h_oe),
    .pin(muxed_bus_in)
  );
  // Store model, one cycle read latency; records every commit
  always @(posedge clk) begin
    if (mem_rd)
      mem_rdata <= store[{mem_xram, mem_addr}];
    if (mem_wr) begin
      store[{mem_xram, mem_addr}] <= mem_wdata;
      {last_x, last_a, last_d} <= {mem_xram, mem_addr, mem_wdata};
      wcnt <= wcnt + 1;
    end
    if (muxed_bus_oe)
      ocnt <= ocnt + 1;
    // Both sides driving the pins at once is a contention
    if (muxed_bus_oe && h_oe)
      clash <= clash + 1;
  end
  ////////////////////////////////////////
  // Writes then reads in one bank, short and long strobes
  task automatic t_rw(input logic x);
    logic [7:0] q;
    int         oc;
    xram_select = x;
    mhp_host_model_inst.cyc(8'hFF, 1'b1, 8'hA5 ^ {8{x}}, 1'b1, 1'b1, 4, q);
    `CHK({last_x, last_a, last_d}, {x, 8'hFF, 8'hA5 ^ {8{x}}})
    mhp_host_model_inst.cyc(8'h00, 1'b1, {7'h2D, x}, 1'b1, 1'b1, 14, q);
    `CHK({last_x, last_a, last_d}, {x, 8'h00, 7'h2D, x})
    oc = ocnt;
    mhp_host_model_inst.cyc(8'hFF, 1'b0, 8'h00, 1'b1, 1'b1, 10, q);
    `CHK(q, 8'hA5 ^ {8{x}})
    `CHK(ocnt > oc, 1'b1)
    `CHK(muxed_bus_oe, 1'b0)
    mhp_host_model_inst.cyc(8'h00, 1'b0, 8'h00, 1'b1, 1'b1, 8, q);
    `CHK(q, {7'h2D, x})
  endtask
  // Strobes without address phase or chip select move no data
  task automatic t_refused();
    logic [7:0] q;
    int         wc;
    int         oc;
    xram_select = 1'b0;
    mhp_host_model_inst.cyc(8'hFF, 1'b0, 8'h00, 1'b1, 1'b1, 10, q);
    `CHK(q, 8'hA5)
    wc = wcnt;
    oc = ocnt;
    // Gap so the old address strobe is not taken as this read's start
    mhp_host_model_inst.tick(8);
    mhp_host_model_inst.cyc(8'hFF, 1'b0, 8'h00, 1'b1, 1'b0, 10, q);
    mhp_host_model_inst.cyc(8'h3C, 1'b1, 8'hC3, 1'b0, 1'b1, 6, q);
    `CHK(mem_addr, 8'h3C)
    mhp_host_model_inst.cyc(8'h3C, 1'b0, 8'h00, 1'b0, 1'b1, 10, q);
    `CHK({wcnt, ocnt}, {wc, oc})
    `CHK(clash, 0)
  endtask
  // Verdict and end of run
  task automatic stop_test();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (10) @(posedge clk);
    #1 reset_n = 1'b1;
    repeat (8) @(posedge clk);
    #1;
    t_rw(1'b0);
    t_rw(1'b1);
    t_refused();
    stop_test();
  end
  // Watchdog, several times the expected run
  initial begin
    #20us;
    miscompares++;
    stop_test();
  end
endmodule
